// [dvmcr_pkg.sv]
// Constants and types shared by the voltmeter counter and its digit mux.
// Assumes a single 200 MHz clock domain with an active-low async reset.
package dvmcr_pkg;

    localparam int unsigned   DVMCR_NDEC      = 5;
    localparam int unsigned   DVMCR_NFULL     = 4;
    localparam int unsigned   DVMCR_NSYNC_IN  = 6;
    localparam int unsigned   DVMCR_NEV       = 4;

    // Counter values
    localparam logic [1:0]    DVMCR_PRESET_TOP = 2'h3;
    localparam logic [3:0]    DVMCR_BCD_MAX    = 4'h9;
    localparam logic [3:0]    DVMCR_BCD_ZERO   = 4'h0;
    localparam logic [3:0]    DVMCR_PAUSE_CNT  = 4'ha;
    localparam logic [3:0]    DVMCR_CLOSE_THOU = 4'h9;
    localparam logic [3:0]    DVMCR_DIV100_HI  = 4'h5;
    localparam logic [3:0]    DVMCR_BCD_BLANK  = 4'hf;

    // Synchronised pin positions
    localparam int unsigned   DVMCR_PIN_CP    = 0;
    localparam int unsigned   DVMCR_PIN_MP    = 1;
    localparam int unsigned   DVMCR_PIN_XFER  = 2;
    localparam int unsigned   DVMCR_PIN_STEP  = 3;
    localparam int unsigned   DVMCR_PIN_BLANK = 4;
    localparam int unsigned   DVMCR_PIN_DP    = 5;

    // Register byte addresses
    localparam logic [7:0]    DVMCR_ADDR_STATUS = 8'h00;
    localparam logic [7:0]    DVMCR_ADDR_MASK   = 8'h04;
    localparam logic [7:0]    DVMCR_ADDR_RESULT = 8'h08;
    localparam logic [7:0]    DVMCR_ADDR_COUNT  = 8'h0c;

    // Status event bits
    localparam int unsigned   DVMCR_EV_XFER = 0;
    localparam int unsigned   DVMCR_EV_OVR  = 1;
    localparam int unsigned   DVMCR_EV_UNDR = 2;
    localparam int unsigned   DVMCR_EV_MISS = 3;

    localparam logic [3:0]    DVMCR_MASK_RST = 4'h0;

    typedef enum logic [4:0] {
        DVMCR_SEL_A = 5'h01,
        DVMCR_SEL_B = 5'h02,
        DVMCR_SEL_C = 5'h04,
        DVMCR_SEL_D = 5'h08,
        DVMCR_SEL_E = 5'h10
    } dvmcr_sel_e;

    typedef logic [DVMCR_NDEC-1:0][3:0] dvmcr_digits_t;

endpackage

// [dvmcr_disp_if.sv]
// Carries latched digits and display controls from counter to digit mux.
// Both ends sit on the same clock.
interface dvmcr_disp_if;
    import dvmcr_pkg::*;

    dvmcr_digits_t digits;
    logic          blank_all;
    logic          step_rise;
    logic          dp_lvl;

    modport cnt (output digits, output blank_all, output step_rise,
                 output dp_lvl);
    modport mux (input digits, input blank_all, input step_rise,
                 input dp_lvl);
endinterface

// [dvmcr_digit_mux.sv]
// Digit multiplexer: one-hot decade select ring, leading-zero blanking.
// Assumes step and boundary levels are already synchronised.
module dvmcr_digit_mux
    import dvmcr_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    dvmcr_disp_if.mux          disp,
    output logic [3:0]         bcd,
    output logic [4:0]         sel
);
    dvmcr_sel_e                state_r;
    dvmcr_sel_e                state_nxt;
    logic [DVMCR_NDEC-1:0]     bnd_r;
    logic [DVMCR_NDEC:0]       lead_zero;
    logic [DVMCR_NDEC-1:0]     above_bnd;
    logic [3:0]                bcd_r;
    logic [3:0]                bcd_nxt;

    // [R17] Ring advance
    always_comb begin
        state_nxt = state_r;
        if (disp.step_rise) begin
            case (state_r)
                DVMCR_SEL_A: state_nxt = DVMCR_SEL_B;
                DVMCR_SEL_B: state_nxt = DVMCR_SEL_C;
                DVMCR_SEL_C: state_nxt = DVMCR_SEL_D;
                DVMCR_SEL_D: state_nxt = DVMCR_SEL_E;
                DVMCR_SEL_E: state_nxt = DVMCR_SEL_A;
                default:     state_nxt = DVMCR_SEL_A;
            endcase
        end
    end

    // [R8] Own step input
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= DVMCR_SEL_A;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign lead_zero[DVMCR_NDEC] = 1'b1;
    assign above_bnd[0]          = 1'b0;

    genvar k;
    generate
        for (k = 0; k < DVMCR_NDEC; k++) begin : g_dec
            // [R9] Boundary capture
            // Sampled as the decade is left, so the fed-back select
            // has settled on the pin by then.
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    bnd_r[k] <= 1'b0;
                end else if (disp.step_rise && state_r[k]) begin
                    bnd_r[k] <= disp.dp_lvl;
                end
            end
            assign lead_zero[k] = lead_zero[k+1] &&
                                  (disp.digits[k] == DVMCR_BCD_ZERO);
            if (k > 0) begin : g_above
                assign above_bnd[k] = above_bnd[k-1] | bnd_r[k-1];
            end
        end
    endgenerate

    // [R6] Selected digit
    // [R9] Blank leading zeros
    always_comb begin
        bcd_nxt = DVMCR_BCD_ZERO;
        for (int i = 0; i < DVMCR_NDEC; i++) begin
            if (state_nxt[i]) begin
                if (disp.blank_all || (above_bnd[i] && lead_zero[i])) begin
                    bcd_nxt = DVMCR_BCD_BLANK;
                end else begin
                    bcd_nxt = disp.digits[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bcd_r <= DVMCR_BCD_ZERO;
        end else begin
            bcd_r <= bcd_nxt;
        end
    end

    // [R7] One-hot select
    assign sel = state_r;
    assign bcd = bcd_r;
endmodule

// [dvmcr_counter.sv]
// Function
// [R1] Latch count-phase flag two into a holding latch, drive it out.
// [R2] With full scale 19,999, latched flag high means overrange.
// [R3] Provide divide-by-2,000 tap from the counter chain as underrange cue.
// [R4] Tap still low at transfer means count below 10 percent of full scale.
// [R5] System supplies power-on reset; counters need it to start defined.
// [R6] One decade at a time appears on four BCD outputs 1,2,4,8.
// [R7] Exactly one of five decade selects is high, naming shown decade.
// [R8] Digit mux advances on its own step input, may be fed by div-100.
// [R9] Fed-back decade select on boundary input blanks leading zeros left.
// [R10] System ties factory test input high; it is never driven.
// [R11] External comparator issues transfer when integrator crosses null.
// [R12] External switch gating derives only from the two phase flags.
// [R13] Counters step on LOW-to-HIGH edge of active-low count clock.
// [R14] Count clock edge with master preset low loads 30,000.
// [R15] On reaching 00,000 ignore the next 10 count pulses, then resume.
// [R16] One transfer accepted between 00,000 and 39,000; loads the latches.
// [R17] Each step edge moves select to next decade, E wraps to A.
//
// Four-and-a-half decade voltmeter counter with register port and irq.
// Assumes all pins are asynchronous and slow next to the 200 MHz clock;
// the test pin is tied off outside and so has no port here.
module dvmcr_counter
    import dvmcr_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          arst_n,
    input  wire logic          count_clock_n,
    input  wire logic          master_preset_n,
    input  wire logic          transfer_n,
    input  wire logic          step_n,
    input  wire logic          blank_n,
    input  wire logic          blank_boundary_in,
    input  wire logic [7:0]    addr,
    input  wire logic [31:0]   wr_data,
    input  wire logic          wr_en,
    input  wire logic          rd_en,
    output logic [31:0]        rd_data,
    output logic               irq,
    output logic               phase_flag_one,
    output logic               phase_flag_two,
    output logic               overrange_latch_out,
    output logic               div100_out,
    output logic               div2000_out,
    output logic               bcd_weight_one,
    output logic               bcd_weight_two,
    output logic               bcd_weight_four,
    output logic               bcd_weight_eight,
    output logic               decade_select_a,
    output logic               decade_select_b,
    output logic               decade_select_c,
    output logic               decade_select_d,
    output logic               decade_select_e
);
    logic [DVMCR_NSYNC_IN-1:0] pin_raw;
    logic [DVMCR_NSYNC_IN-1:0] meta_r;
    logic [DVMCR_NSYNC_IN-1:0] sync_r;
    logic [DVMCR_NSYNC_IN-1:0] prev_r;
    logic                      cp_rise;
    logic                      xfer_fall;

    logic [DVMCR_NFULL-1:0][3:0] dec_r;
    logic [DVMCR_NFULL-1:0][3:0] dec_inc;
    logic [1:0]                top_r;
    logic [1:0]                top_inc;
    logic                      carry;
    logic                      wrap_zero;
    logic                      at_close;
    logic [3:0]                pause_r;
    logic                      count_step;
    logic                      armed_r;
    logic                      xfer_ok;

    logic [DVMCR_NFULL-1:0][3:0] lat_dec_r;
    logic [1:0]                lat_top_r;
    logic                      ovr_r;
    logic                      div100_r;
    logic                      div2000_r;
    logic                      flag1_r;
    logic                      flag2_r;

    logic [DVMCR_NEV-1:0]      ev;
    logic [DVMCR_NEV-1:0]      status_r;
    logic [DVMCR_NEV-1:0]      status_clr;
    logic [DVMCR_NEV-1:0]      mask_r;
    logic [31:0]               rd_data_r;
    logic [31:0]               rd_data_nxt;
    logic                      irq_r;

    logic [3:0]                bcd;
    logic [4:0]                sel;

    dvmcr_disp_if disp ();

    assign pin_raw[DVMCR_PIN_CP]    = count_clock_n;
    assign pin_raw[DVMCR_PIN_MP]    = master_preset_n;
    assign pin_raw[DVMCR_PIN_XFER]  = transfer_n;
    assign pin_raw[DVMCR_PIN_STEP]  = step_n;
    assign pin_raw[DVMCR_PIN_BLANK] = blank_n;
    assign pin_raw[DVMCR_PIN_DP]    = blank_boundary_in;

    // Two-flop synchronisers; prev_r only looks at the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= {DVMCR_NSYNC_IN{1'b1}};
            sync_r <= {DVMCR_NSYNC_IN{1'b1}};
            prev_r <= {DVMCR_NSYNC_IN{1'b1}};
        end else begin
            meta_r <= pin_raw;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // [R13] Rising count clock
    assign cp_rise   = sync_r[DVMCR_PIN_CP] && !prev_r[DVMCR_PIN_CP];
    assign xfer_fall = !sync_r[DVMCR_PIN_XFER] && prev_r[DVMCR_PIN_XFER];

    // BCD ripple increment across the full decades, then the binary top
    always_comb begin
        carry = 1'b1;
        for (int i = 0; i < DVMCR_NFULL; i++) begin
            dec_inc[i] = dec_r[i];
            if (carry) begin
                if (dec_r[i] == DVMCR_BCD_MAX) begin
                    dec_inc[i] = DVMCR_BCD_ZERO;
                end else begin
                    dec_inc[i] = dec_r[i] + 4'h1;
                    carry      = 1'b0;
                end
            end
        end
        top_inc   = top_r + {1'b0, carry};
        wrap_zero = carry && (top_r == DVMCR_PRESET_TOP);
    end

    assign count_step = cp_rise && sync_r[DVMCR_PIN_MP] &&
                        (pause_r == 4'h0);
    // 39,000 is entered when the thousands digit steps to nine in top 3
    assign at_close   = count_step && (top_inc == DVMCR_PRESET_TOP) &&
                        (dec_inc[3] == DVMCR_CLOSE_THOU) &&
                        (dec_inc[2:0] == '0);

    // [R5] Defined start needs reset
    // [R14] Preset to 30,000
    // [R15] Ten-count pause
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dec_r   <= '0;
            top_r   <= 2'h0;
            pause_r <= 4'h0;
        end else if (cp_rise) begin
            if (!sync_r[DVMCR_PIN_MP]) begin
                dec_r   <= '0;
                top_r   <= DVMCR_PRESET_TOP;
                pause_r <= 4'h0;
            end else if (pause_r != 4'h0) begin
                pause_r <= pause_r - 4'h1;
            end else begin
                dec_r <= dec_inc;
                top_r <= top_inc;
                if (wrap_zero) begin
                    pause_r <= DVMCR_PAUSE_CNT;
                end
            end
        end
    end

    // [R16] Single transfer window
    assign xfer_ok = xfer_fall && armed_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_r <= 1'b0;
        end else if (cp_rise && !sync_r[DVMCR_PIN_MP]) begin
            armed_r <= 1'b0;
        end else if (count_step && wrap_zero) begin
            armed_r <= 1'b1;
        end else if (xfer_ok || at_close) begin
            armed_r <= 1'b0;
        end
    end

    // [R16] Load output latches
    // [R1] Hold flag two
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lat_dec_r <= '0;
            lat_top_r <= 2'h0;
            ovr_r     <= 1'b0;
        end else if (xfer_ok) begin
            lat_dec_r <= dec_r;
            lat_top_r <= top_r;
            ovr_r     <= top_r[1];
        end else if (at_close && armed_r) begin
            // No null crossing in the whole window: far past full scale
            ovr_r <= 1'b1;
        end
    end

    // [R3] Divide-by-2,000 tap
    // [R8] Divide-by-100 step source
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div100_r  <= 1'b0;
            div2000_r <= 1'b0;
            flag1_r   <= 1'b0;
            flag2_r   <= 1'b0;
        end else begin
            div100_r  <= (dec_r[1] >= DVMCR_DIV100_HI);
            div2000_r <= dec_r[3][1];
            flag1_r   <= top_r[0];
            flag2_r   <= top_r[1];
        end
    end

    // [R4] Underrange at transfer
    // [R2] Overrange at transfer
    always_comb begin
        ev                = '0;
        ev[DVMCR_EV_XFER] = xfer_ok;
        ev[DVMCR_EV_OVR]  = xfer_ok && top_r[1];
        ev[DVMCR_EV_UNDR] = xfer_ok && (top_r == 2'h0) &&
                            (dec_r[3][3:1] == 3'h0);
        ev[DVMCR_EV_MISS] = at_close && armed_r;
    end

    // Read of status clears it, but a new event in that cycle survives
    assign status_clr = (rd_en && addr == DVMCR_ADDR_STATUS) ?
                        {DVMCR_NEV{1'b1}} : '0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~status_clr) | ev;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_r <= DVMCR_MASK_RST;
        end else if (wr_en && addr == DVMCR_ADDR_MASK) begin
            mask_r <= wr_data[DVMCR_NEV-1:0];
        end
    end

    always_comb begin
        rd_data_nxt = 32'h0;
        case (addr)
            DVMCR_ADDR_STATUS: rd_data_nxt = {28'h0, status_r};
            DVMCR_ADDR_MASK:   rd_data_nxt = {28'h0, mask_r};
            DVMCR_ADDR_RESULT: rd_data_nxt = {13'h0, ovr_r, lat_top_r,
                                              lat_dec_r};
            DVMCR_ADDR_COUNT:  rd_data_nxt = {9'h0, armed_r, pause_r,
                                              top_r, dec_r};
            default:           rd_data_nxt = 32'h0;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_data_r <= 32'h0;
            irq_r     <= 1'b0;
        end else begin
            rd_data_r <= rd_en ? rd_data_nxt : 32'h0;
            irq_r     <= |(status_r & mask_r);
        end
    end

    // Half decade shows only the ten-thousands bit of the latched top
    assign disp.digits    = {{3'h0, lat_top_r[0]}, lat_dec_r};
    assign disp.blank_all = !sync_r[DVMCR_PIN_BLANK];
    assign disp.step_rise = sync_r[DVMCR_PIN_STEP] &&
                            !prev_r[DVMCR_PIN_STEP];
    assign disp.dp_lvl    = sync_r[DVMCR_PIN_DP];

    dvmcr_digit_mux u_mux (
        .clk    (clk),
        .arst_n (arst_n),
        .disp   (disp),
        .bcd    (bcd),
        .sel    (sel)
    );

    assign rd_data             = rd_data_r;
    assign irq                 = irq_r;
    // [R12] Flags for switch gating
    assign phase_flag_one      = flag1_r;
    assign phase_flag_two      = flag2_r;
    assign overrange_latch_out = ovr_r;
    assign div100_out          = div100_r;
    assign div2000_out         = div2000_r;
    assign bcd_weight_one      = bcd[0];
    assign bcd_weight_two      = bcd[1];
    assign bcd_weight_four     = bcd[2];
    assign bcd_weight_eight    = bcd[3];
    assign decade_select_a     = sel[0];
    assign decade_select_b     = sel[1];
    assign decade_select_c     = sel[2];
    assign decade_select_d     = sel[3];
    assign decade_select_e     = sel[4];
endmodule

// [dvmcr_counter_assertions.sv]
// Checker on the voltmeter counter top ports, bound at the foot.
// Assumes pins move just after clk and idle high.
module dvmcr_counter_chk (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        count_clock_n,
    input wire logic        step_n,
    input wire logic        blank_n,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wr_data,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rd_data,
    input wire logic        phase_flag_one,
    input wire logic        phase_flag_two,
    input wire logic        div100_out,
    input wire logic        div2000_out,
    input wire logic        bcd_weight_one,
    input wire logic        bcd_weight_two,
    input wire logic        bcd_weight_four,
    input wire logic        bcd_weight_eight,
    input wire logic        decade_select_a,
    input wire logic        decade_select_b,
    input wire logic        decade_select_c,
    input wire logic        decade_select_d,
    input wire logic        decade_select_e
);
    import dvmcr_pkg::*;

    logic [4:0] sel;
    logic [3:0] bcd;
    logic [3:0] cp_age_r;
    logic [3:0] st_age_r;
    logic       cp_q_r;
    logic       st_q_r;

    assign sel = {decade_select_e, decade_select_d, decade_select_c,
                  decade_select_b, decade_select_a};
    assign bcd = {bcd_weight_eight, bcd_weight_four, bcd_weight_two,
                  bcd_weight_one};

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Cycles since a pin rose; sync plus output stage lands at 1 to 7
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cp_q_r   <= 1'b1;
            st_q_r   <= 1'b1;
            cp_age_r <= 4'hf;
            st_age_r <= 4'hf;
        end else begin
            cp_q_r   <= count_clock_n;
            st_q_r   <= step_n;
            cp_age_r <= (count_clock_n && !cp_q_r) ? 4'h0
                      : cp_age_r + {3'h0, ~&cp_age_r};
            st_age_r <= (step_n && !st_q_r) ? 4'h0
                      : st_age_r + {3'h0, ~&st_age_r};
        end
    end

    sequence s_mask_wr;
        wr_en && addr == DVMCR_ADDR_MASK;
    endsequence
    sequence s_mask_rd;
        rd_en && addr == DVMCR_ADDR_MASK;
    endsequence
    sequence s_blank_held;
        (!blank_n) [*8];
    endsequence

    property p_sel_onehot;
        $onehot(sel);
    endproperty
    property p_sel_ring;
        !$stable(sel) |-> sel == {$past(sel[3:0]), $past(sel[4])};
    endproperty
    property p_sel_cause;
        !$stable(sel) |-> st_age_r inside {[4'h1:4'h7]};
    endproperty
    property p_flag_cause;
        !$stable({phase_flag_two, phase_flag_one})
            |-> cp_age_r inside {[4'h1:4'h7]};
    endproperty
    property p_div_cause;
        !$stable({div2000_out, div100_out})
            |-> cp_age_r inside {[4'h1:4'h7]};
    endproperty
    property p_blank_all;
        s_blank_held ##0 !$stable(sel) |-> bcd == DVMCR_BCD_BLANK;
    endproperty
    property p_rd_idle;
        !rd_en |=> rd_data == 32'h0;
    endproperty
    property p_mask_read;
        s_mask_wr ##2 s_mask_rd
            |=> rd_data == {28'h0, $past(wr_data[3:0], 3)};
    endproperty

    a_sel_onehot: assert property (p_sel_onehot)
        else $error("decade select not one-hot");
    a_sel_ring: assert property (p_sel_ring)
        else $error("decade select skipped a place");
    a_sel_cause: assert property (p_sel_cause)
        else $error("decade select moved without a step");
    a_flag_cause: assert property (p_flag_cause)
        else $error("phase flags moved without a count rise");
    a_div_cause: assert property (p_div_cause)
        else $error("divider taps moved without a count rise");
    a_blank_all: assert property (p_blank_all)
        else $error("digit shown while display blanked");
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside a read");
    a_mask_read: assert property (p_mask_read)
        else $error("mask read back differs from write");
endmodule

bind dvmcr_counter dvmcr_counter_chk chk_u (.*);

// [dvmcr_analog_model.sv]
// Far side: integrator, null comparator and digit feedback switch.
// Assumes the counter syncs pins; each phase is held 4 clocks or more.
module dvmcr_analog_model (
    input  wire logic       clk,
    input  wire logic       div100_out,
    input  wire logic       phase_flag_one,
    input  wire logic       phase_flag_two,
    input  wire logic [4:0] sel,
    output logic            count_clock_n,
    output logic            master_preset_n,
    output logic            transfer_n,
    output logic            step_n,
    output logic            blank_boundary_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import dvmcr_pkg::*;

    logic step_drv;
    logic use_div;
    logic deint;
    int   fb;

    initial begin
        count_clock_n   = 1'b1;
        master_preset_n = 1'b1;
        transfer_n      = 1'b1;
        step_drv        = 1'b1;
        use_div         = 1'b0;
        fb              = 5;
    end

    assign deint = !phase_flag_one && !phase_flag_two;
    assign step_n = use_div ? div100_out : step_drv;
    // digit fed back; 5 pulls low, so nothing is blanked
    assign blank_boundary_in = (fb < 5) ? sel[fb[2:0]] : 1'b0;

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            count_clock_n <= 1'b0;
            hold(4);
            count_clock_n <= 1'b1;
            hold(3);
        end
        hold(8);
        @(negedge clk);
    endtask

    task automatic preset();
        @(posedge clk);
        master_preset_n <= 1'b0;
        pulses(1);
        @(posedge clk);
        master_preset_n <= 1'b1;
    endtask

    task automatic transfer();
        @(posedge clk);
        transfer_n <= !deint;
        hold(4);
        transfer_n <= 1'b1;
        hold(6);
        @(negedge clk);
    endtask

    task automatic step_pulse();
        @(posedge clk);
        step_drv <= 1'b0;
        hold(4);
        step_drv <= 1'b1;
        hold(7);
        @(negedge clk);
    endtask
endmodule

// [dvmcr_counter_tb.sv]
// Bench for the voltmeter counter: register port tasks, far-side model.
// Assumes the model tasks return off the clock edge with outputs settled.
module dvmcr_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dvmcr_pkg::*;

    logic        clk, arst_n, blank_n, wr_en, rd_en, irq;
    logic [7:0]  addr;
    logic [31:0] wr_data, rd_data, rdv;
    logic        phase_flag_one, phase_flag_two, overrange_latch_out;
    logic        div100_out, div2000_out, count_clock_n, master_preset_n;
    logic        transfer_n, step_n, blank_boundary_in;
    logic [3:0]  bcd;
    logic [4:0]  sel;
    logic        bcd_weight_one, bcd_weight_two, bcd_weight_four;
    logic        bcd_weight_eight, decade_select_a, decade_select_b;
    logic        decade_select_c, decade_select_d, decade_select_e;
    logic [3:0]  lat [5];
    int          err_count, tests_run, cyc, cur;

    // test input has no port; tied high outside
    dvmcr_counter dut_u (.*);
    dvmcr_analog_model far_u (.*);
    assign bcd = {bcd_weight_eight, bcd_weight_four, bcd_weight_two,
                  bcd_weight_one};
    assign sel = {decade_select_e, decade_select_d, decade_select_c,
                  decade_select_b, decade_select_a};

    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // Whole run needs about 98,000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 110000) begin
            err_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= w;
        rd_en   <= !w;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        #1 rdv = rd_data;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdv, exp);
    endtask

    function automatic logic [3:0] shown(input int d, input int fb);
        logic zero;
        zero = 1'b1;
        for (int k = d; k < 5; k++)
            zero &= (lat[k] == 4'h0);
        return (d > fb && zero) ? DVMCR_BCD_BLANK : lat[d];
    endfunction

    task automatic scan(input int fb, input logic look);
        repeat (5) begin
            far_u.step_pulse();
            cur = (cur + 1) % 5;
            chk({27'h0, sel}, 32'h1 << cur);
            if (look)
                chk({28'h0, bcd}, {28'h0, shown(cur, fb)});
        end
    endtask

    initial begin
        arst_n  = 1'b0;
        blank_n = 1'b1;
        addr    = 8'h00;
        wr_data = 32'h0;
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        lat     = '{4'h0, 4'h2, 4'h1, 4'h0, 4'h0};
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        chk({27'h0, sel}, 32'h1);
        rdc(DVMCR_ADDR_MASK, 32'h0);
        bus(1'b1, 8'h10, 32'hffff_ffff);
        rdc(8'h10, 32'h0);
        far_u.transfer();
        rdc(DVMCR_ADDR_STATUS, 32'h0);
        far_u.preset();
        chk({phase_flag_two, phase_flag_one}, 32'h3);
        rdc(DVMCR_ADDR_COUNT, 32'h0003_0000);
        far_u.pulses(9999);
        rdc(DVMCR_ADDR_COUNT, 32'h0003_9999);
        far_u.pulses(1);
        chk({phase_flag_two, phase_flag_one}, 32'h0);
        rdc(DVMCR_ADDR_COUNT, 32'h0068_0000);
        far_u.pulses(10);
        rdc(DVMCR_ADDR_COUNT, 32'h0040_0000);
        far_u.pulses(120);
        rdc(DVMCR_ADDR_COUNT, 32'h0040_0120);
        far_u.transfer();
        chk(irq, 32'h0);
        rdc(DVMCR_ADDR_RESULT, 32'h0000_0120);
        chk(overrange_latch_out, 32'h0);
        bus(1'b1, DVMCR_ADDR_MASK, 32'h1);
        rdc(DVMCR_ADDR_MASK, 32'h1);
        chk(irq, 32'h1);
        rdc(DVMCR_ADDR_STATUS, 32'h5);
        repeat (3) @(negedge clk);
        chk(irq, 32'h0);
        far_u.pulses(5);
        far_u.transfer();
        rdc(DVMCR_ADDR_STATUS, 32'h0);
        rdc(DVMCR_ADDR_RESULT, 32'h0000_0120);
        for (int f = 0; f < 6; f++) begin
            far_u.fb = f;
            scan(f, 1'b0);
            scan(f, 1'b0);
            scan(f, 1'b1);
        end
        @(posedge clk);
        blank_n <= 1'b0;
        far_u.step_pulse();
        cur = (cur + 1) % 5;
        chk({28'h0, bcd}, {28'h0, DVMCR_BCD_BLANK});
        @(posedge clk);
        blank_n <= 1'b1;
        far_u.pulses(24);
        chk(div100_out, 32'h0);
        far_u.use_div = 1'b1;
        far_u.pulses(1);
        cur = (cur + 1) % 5;
        chk(div100_out, 32'h1);
        chk({27'h0, sel}, 32'h1 << cur);
        far_u.use_div = 1'b0;
        far_u.pulses(1849);
        chk(div2000_out, 32'h0);
        far_u.pulses(1);
        chk(div2000_out, 32'h1);
        rdc(DVMCR_ADDR_COUNT, 32'h0000_2000);
        stop_test();
    end
endmodule
